// ===== rtl/imra_pkg.sv
/*
 * Constants for the indirect MMD register access block: management
 * addresses, control field layout, function codes and target registers.
 * Assumes a management front end that decodes frames into strobes.
 */
package imra_pkg;
    // ------------------------------------------------------------
    // management addresses, reset values, control fields and function codes
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_INDIRECT_CTRL      = 5'h0D;
    localparam logic [4:0]  ADDR_INDIRECT_ADDR_DATA = 5'h0E;
    localparam logic [15:0] RST_INDIRECT_CTRL       = 16'h0000;
    localparam logic [15:0] RST_ADDR_DATA           = 16'h0000;
    localparam logic [15:0] RST_TARGET              = 16'h0000;
    localparam int          FUNC_HI                 = 15;
    localparam int          FUNC_LO                 = 14;
    localparam int          DEV_HI                  = 4;
    localparam int          DEV_LO                  = 0;
    localparam logic [1:0]  FUNC_ADDRESS            = 2'h0;
    localparam logic [1:0]  FUNC_DATA               = 2'h1;
    localparam logic [1:0]  FUNC_DATA_INC_RW        = 2'h2;
    localparam logic [1:0]  FUNC_DATA_INC_WR        = 2'h3;
    // ------------------------------------------------------------
    // target map
    // ------------------------------------------------------------
    localparam logic [4:0]  MMD_LINE_MEDIA          = 5'h01;
    localparam logic [4:0]  MMD_CODING              = 5'h03;
    localparam logic [15:0] REG_LINE_MEDIA_CONTROL_ONE   = 16'h0000;
    localparam logic [15:0] REG_CODING_CONTROL_ONE       = 16'h0000;
    localparam logic [15:0] REG_TRANSMIT_DISABLE         = 16'h0009;
    localparam logic [15:0] REG_LINE_TEST_MODE_CONTROL   = 16'h08F8;
    localparam logic [15:0] REG_LINE_LINK_STATUS         = 16'h8302;
    localparam logic [15:0] REG_RECEIVE_ERROR_METRIC     = 16'h830B;
endpackage

// ===== rtl/imra_top.sv
/*
 * Indirect access path from the management register space into the MMD
 * register space. Holds the indirect control register, the address/data
 * port, a per-MMD held address and the writable target registers.
 * Assumes the management front end gives one-cycle read/write strobes
 * synchronous to ref_clk; read data is registered one cycle later.
 */
`timescale 1ns/1ns
`default_nettype none
module imra_top (
    input  wire logic       ref_clk,           // 20 MHz clock
    input  wire logic       nrst,              // synchronous reset, active low
    input  wire logic       mgmt_wr,           // one-cycle write strobe
    input  wire logic       mgmt_rd,           // one-cycle read strobe
    input  wire logic [4:0] mgmt_addr,         // management register address
    input  wire logic [15:0] mgmt_wdata,       // write data
    output logic [15:0]     mgmt_rdata,        // read data, valid with rvalid
    output logic            mgmt_rvalid,       // read answer pulse
    input  wire logic [15:0] line_link_status_in, // live link status
    input  wire logic [15:0] receive_error_metric_in, // live error metric
    output logic [15:0]     line_media_control_one,      // media control
    output logic [15:0]     coding_sublayer_control_one, // coding control
    output logic [15:0]     transmit_disable,            // transmit disable
    output logic [15:0]     line_test_mode_control       // test mode control
);
    import imra_pkg::*;

    logic [15:0] indirect_ctrl_q;
    logic [15:0] mmd_addr_q [32];
    logic [1:0]  indirect_function_select;
    logic [4:0]  target_device_select;
    logic        port_wr;
    logic        port_rd;
    logic        data_wr;
    logic        data_rd;
    logic        inc;
    logic [15:0] cur_addr;
    logic [15:0] target_rdata;

    assign indirect_function_select = indirect_ctrl_q[FUNC_HI:FUNC_LO];
    assign target_device_select     = indirect_ctrl_q[DEV_HI:DEV_LO];
    assign port_wr  = mgmt_wr && (mgmt_addr == ADDR_INDIRECT_ADDR_DATA);
    assign port_rd  = mgmt_rd && (mgmt_addr == ADDR_INDIRECT_ADDR_DATA);
    assign data_wr  = port_wr && (indirect_function_select != FUNC_ADDRESS);
    assign data_rd  = port_rd && (indirect_function_select != FUNC_ADDRESS);
    assign cur_addr = mmd_addr_q[target_device_select];

    // ------------------------------------------------------------
    // post increment decision
    // ------------------------------------------------------------
    // 01 never moves, 10 moves on both, 11 moves on writes only
    always_comb begin
        unique case (indirect_function_select)
            FUNC_ADDRESS:     inc = 1'b0;
            FUNC_DATA:        inc = 1'b0;
            FUNC_DATA_INC_RW: inc = data_wr || data_rd;
            FUNC_DATA_INC_WR: inc = data_wr;
        endcase
    end

    // ------------------------------------------------------------
    // indirect control register
    // ------------------------------------------------------------
    // reserved bits are never stored, so they read back as zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            indirect_ctrl_q <= RST_INDIRECT_CTRL;
        end else if (mgmt_wr && mgmt_addr == ADDR_INDIRECT_CTRL) begin
            indirect_ctrl_q <= {mgmt_wdata[FUNC_HI:FUNC_LO], 9'h000, mgmt_wdata[DEV_HI:DEV_LO]};
        end
    end

    // ------------------------------------------------------------
    // held address per MMD
    // ------------------------------------------------------------
    // one address per device so switching MMDs keeps each position
    // the port reads back the held address in address function, so this is its reset value
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                mmd_addr_q[i] <= RST_ADDR_DATA;
            end
        end else if (port_wr && indirect_function_select == FUNC_ADDRESS) begin
            mmd_addr_q[target_device_select] <= mgmt_wdata;
        end else if (inc) begin
            mmd_addr_q[target_device_select] <= cur_addr + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // target registers
    // ------------------------------------------------------------
    // writes land at the address held before any increment
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            line_media_control_one      <= RST_TARGET;
            coding_sublayer_control_one <= RST_TARGET;
            transmit_disable            <= RST_TARGET;
            line_test_mode_control      <= RST_TARGET;
        end else if (data_wr) begin
            if (target_device_select == MMD_LINE_MEDIA) begin
                if (cur_addr == REG_LINE_MEDIA_CONTROL_ONE) line_media_control_one <= mgmt_wdata;
                if (cur_addr == REG_TRANSMIT_DISABLE) transmit_disable <= mgmt_wdata;
                if (cur_addr == REG_LINE_TEST_MODE_CONTROL) line_test_mode_control <= mgmt_wdata;
            end
            if (target_device_select == MMD_CODING && cur_addr == REG_CODING_CONTROL_ONE) begin
                coding_sublayer_control_one <= mgmt_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // target read mux
    // ------------------------------------------------------------
    // unmapped target registers read as zero; status ones are read-only
    always_comb begin
        target_rdata = 16'h0000;
        if (target_device_select == MMD_LINE_MEDIA) begin
            unique case (cur_addr)
                REG_LINE_MEDIA_CONTROL_ONE: target_rdata = line_media_control_one;
                REG_TRANSMIT_DISABLE:       target_rdata = transmit_disable;
                REG_LINE_TEST_MODE_CONTROL: target_rdata = line_test_mode_control;
                REG_LINE_LINK_STATUS:       target_rdata = line_link_status_in;
                REG_RECEIVE_ERROR_METRIC:   target_rdata = receive_error_metric_in;
                default:                    target_rdata = 16'h0000;
            endcase
        end else if (target_device_select == MMD_CODING && cur_addr == REG_CODING_CONTROL_ONE) begin
            target_rdata = coding_sublayer_control_one;
        end
    end

    // ------------------------------------------------------------
    // management read answer
    // ------------------------------------------------------------
    // registered so the outputs come from flip-flops; port in address
    // function returns the held address of the selected MMD
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mgmt_rdata  <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd && mgmt_addr == ADDR_INDIRECT_CTRL) begin
                mgmt_rdata <= indirect_ctrl_q;
            end else if (port_rd) begin
                mgmt_rdata <= data_rd ? target_rdata : cur_addr;
            end else if (mgmt_rd) begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        indirect_ctrl_q[13:5] == 9'h000) else $error("reserved control bits not zero");
    a_ctrl_reset: assert property (@(posedge ref_clk)
        !nrst |=> indirect_ctrl_q == 16'h0000) else $error("control reset wrong");
    a_func01_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_DATA && (port_rd || port_wr)) |=> $stable(cur_addr))
        else $error("address moved in data mode");
    a_func10_inc: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_DATA_INC_RW && port_rd && !mgmt_wr)
        |=> cur_addr == $past(cur_addr) + 16'h0001) else $error("no increment on read");
    a_func11_rd: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_DATA_INC_WR && port_rd && !mgmt_wr) |=> $stable(cur_addr))
        else $error("read moved address in write-increment mode");
    a_func11_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_DATA_INC_WR && port_wr)
        |=> cur_addr == $past(cur_addr) + 16'h0001) else $error("no increment on write");
    a_addr_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_ADDRESS && port_wr && !(mgmt_addr == ADDR_INDIRECT_CTRL))
        |=> cur_addr == $past(mgmt_wdata)) else $error("address not loaded");
    a_txdis_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_wr && target_device_select == MMD_LINE_MEDIA && cur_addr == REG_TRANSMIT_DISABLE)
        |=> transmit_disable == $past(mgmt_wdata)) else $error("transmit disable not written");
    a_rd_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
        mgmt_rd |=> mgmt_rvalid) else $error("read not answered");

    // ------------------------------------------------------------
    // target register checks
    // ------------------------------------------------------------
    // each writable target follows a data write at its own address only
    a_media_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_wr && target_device_select == MMD_LINE_MEDIA && cur_addr == REG_LINE_MEDIA_CONTROL_ONE)
        |=> line_media_control_one == $past(mgmt_wdata)) else $error("media control not written");
    a_coding_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_wr && target_device_select == MMD_CODING && cur_addr == REG_CODING_CONTROL_ONE)
        |=> coding_sublayer_control_one == $past(mgmt_wdata)) else $error("coding control not written");
    a_test_mode_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_wr && target_device_select == MMD_LINE_MEDIA && cur_addr == REG_LINE_TEST_MODE_CONTROL)
        |=> line_test_mode_control == $past(mgmt_wdata)) else $error("test mode control not written");
    a_other_mmd_still: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_wr && target_device_select != MMD_LINE_MEDIA) |=> $stable(line_media_control_one))
        else $error("write to another device reached media control");
    a_addr_fn_no_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        (port_wr && indirect_function_select == FUNC_ADDRESS) |=> $stable(transmit_disable))
        else $error("address load wrote a target register");
    a_func10_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
        (indirect_function_select == FUNC_DATA_INC_RW && port_wr)
        |=> cur_addr == $past(cur_addr) + 16'h0001) else $error("no increment on write in both-increment mode");
    // read path: the answer comes one cycle after the strobe
    a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mgmt_rd && mgmt_addr == ADDR_INDIRECT_CTRL) |=> mgmt_rdata == $past(indirect_ctrl_q))
        else $error("control read wrong");
    a_ctrl_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mgmt_wr && mgmt_addr == ADDR_INDIRECT_CTRL)
        |=> target_device_select == $past(mgmt_wdata[DEV_HI:DEV_LO])) else $error("device field not loaded");
    a_port_addr_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        (port_rd && indirect_function_select == FUNC_ADDRESS) |=> mgmt_rdata == $past(cur_addr))
        else $error("address read wrong");
    a_link_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_rd && target_device_select == MMD_LINE_MEDIA && cur_addr == REG_LINE_LINK_STATUS)
        |=> mgmt_rdata == $past(line_link_status_in)) else $error("link status read wrong");
    a_metric_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        (data_rd && target_device_select == MMD_LINE_MEDIA && cur_addr == REG_RECEIVE_ERROR_METRIC)
        |=> mgmt_rdata == $past(receive_error_metric_in)) else $error("error metric read wrong");
    c_addr_load: cover property (@(posedge ref_clk) indirect_function_select == FUNC_ADDRESS && port_wr);
    c_inc_rw: cover property (@(posedge ref_clk) indirect_function_select == FUNC_DATA_INC_RW && data_rd);
    c_inc_wr: cover property (@(posedge ref_clk) indirect_function_select == FUNC_DATA_INC_WR && data_wr);
    c_coding_write: cover property (@(posedge ref_clk) data_wr && target_device_select == MMD_CODING);
    c_status_read: cover property (@(posedge ref_clk) data_rd && cur_addr == REG_LINE_LINK_STATUS);
endmodule
`default_nettype wire

// ===== test/imra_host_model.sv
/*
 * Management host model: issues one-cycle write and read strobes to the
 * indirect access block and collects read answers.
 * Assumes the strobe is taken at a rising edge and rvalid follows one cycle later.
 */
`timescale 1ns/1ns
`default_nettype none
module imra_host_model (
    input  wire logic        ref_clk,    // management clock
    output var  logic        mgmt_wr,    // write strobe
    output var  logic        mgmt_rd,    // read strobe
    output var  logic [4:0]  mgmt_addr,  // register address
    output var  logic [15:0] mgmt_wdata, // write data
    input  wire logic [15:0] mgmt_rdata, // read data
    input  wire logic        mgmt_rvalid // read answer pulse
);
    // idle bus at time zero
    initial begin
        mgmt_wr    = 1'b0;
        mgmt_rd    = 1'b0;
        mgmt_addr  = 5'h1F;
        mgmt_wdata = 16'hFFFF;
    end

    // one write; bus is inverted on release so a stale value is never taken for live
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        mgmt_wr    <= 1'b1;
        mgmt_addr  <= a;
        mgmt_wdata <= d;
        @(posedge ref_clk);
        mgmt_wr    <= 1'b0;
        mgmt_addr  <= ~a;
        mgmt_wdata <= ~d;
        #1;
    endtask

    // one read; the answer stands for one cycle only, so it is taken right after the edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge ref_clk);
        mgmt_rd   <= 1'b1;
        mgmt_addr <= a;
        @(posedge ref_clk);
        mgmt_rd   <= 1'b0;
        mgmt_addr <= ~a;
        #1;
        v = mgmt_rvalid;
        d = mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// ===== test/test_imra_top.sv
/*
 * Self-checking bench for the indirect access block: register sequences
 * through the host model, compared with values worked out by hand.
 * Assumes imra_pkg constants and the host model's strobe timing.
 */
`timescale 1ns/1ns
`default_nettype none
module test_imra_top;
    import imra_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        mgmt_wr, mgmt_rd, mgmt_rvalid;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, link_in, metric_in;
    logic [15:0] media, coding, tx_dis, test_mode;
    int          fails = 0;
    int          n_checks = 0;
    int          cycles = 0;
    localparam logic [4:0] C = ADDR_INDIRECT_CTRL;
    localparam logic [4:0] P = ADDR_INDIRECT_ADDR_DATA;

    always #25 ref_clk = ~ref_clk;
    initial begin
        link_in   = 16'h5A3C;
        metric_in = 16'h0123;
    end

    imra_top i_imra_top (.ref_clk(ref_clk), .nrst(nrst), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .line_link_status_in(link_in), .receive_error_metric_in(metric_in),
        .line_media_control_one(media), .coding_sublayer_control_one(coding),
        .transmit_disable(tx_dis), .line_test_mode_control(test_mode));
    imra_host_model i_imra_host_model (.ref_clk(ref_clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [4:0] a, input logic [15:0] d);
        i_imra_host_model.wr(a, d);
    endtask
    // read and demand the answer pulse together with the value
    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        i_imra_host_model.rd(a, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask
    // address function on one MMD, then load the held address
    task automatic ld(input logic [4:0] dev, input logic [15:0] adr);
        w(C, {11'h000, dev});
        w(P, adr);
    endtask

    // hang guard: far above the hundred or so cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        rc(C, RST_INDIRECT_CTRL);
        w(C, 16'h0000);
        rc(P, RST_ADDR_DATA);
        chk(media, RST_TARGET);
        chk(coding, RST_TARGET);
        chk(tx_dis, RST_TARGET);
        chk(test_mode, RST_TARGET);
        // control is always programmed before the port is touched
        w(C, 16'hFFE1);
        rc(C, 16'hC001);
        ld(MMD_LINE_MEDIA, REG_TRANSMIT_DISABLE);
        rc(P, REG_TRANSMIT_DISABLE);
        w(C, 16'h4001);
        w(P, 16'h0005);
        chk(tx_dis, 16'h0005);
        rc(P, 16'h0005);
        w(C, 16'h0001);
        rc(P, REG_TRANSMIT_DISABLE);
        // increment on read, then on write
        w(C, 16'h8001);
        rc(P, 16'h0005);
        w(C, 16'h0001);
        rc(P, 16'h000A);
        ld(MMD_LINE_MEDIA, REG_LINE_TEST_MODE_CONTROL);
        w(C, 16'h8001);
        w(P, 16'hA5A5);
        chk(test_mode, 16'hA5A5);
        w(C, 16'h0001);
        rc(P, 16'h08F9);
        ld(MMD_LINE_MEDIA, REG_LINE_MEDIA_CONTROL_ONE);
        w(C, 16'h4001);
        w(P, 16'h1234);
        chk(media, 16'h1234);
        // write-only increment: reads stay put, a refused write still advances
        ld(MMD_LINE_MEDIA, REG_LINE_LINK_STATUS);
        w(C, 16'hC001);
        rc(P, 16'h5A3C);
        @(posedge ref_clk) link_in <= 16'h3CA5;
        rc(P, 16'h3CA5);
        w(P, 16'hFFFF);
        w(C, 16'h0001);
        rc(P, 16'h8303);
        ld(MMD_LINE_MEDIA, REG_RECEIVE_ERROR_METRIC);
        w(C, 16'h4001);
        w(P, 16'hFFFF);
        rc(P, 16'h0123);
        // second MMD shares the register offset with the first
        ld(MMD_CODING, REG_CODING_CONTROL_ONE);
        w(C, 16'h4003);
        w(P, 16'h0C0D);
        chk(coding, 16'h0C0D);
        chk(media, 16'h1234);
        // unmapped management address reads zero and leaves control alone
        w(5'h05, 16'hFFFF);
        rc(5'h05, 16'h0000);
        rc(C, 16'h4003);
        end_sim();
    end
endmodule
`default_nettype wire
